// File: inc/ltmf_defs.vh
`ifndef LTMF_DEFS_VH
`define LTMF_DEFS_VH

// Register byte offsets
`define LTMF_OFS_CTRL      8'h00
`define LTMF_OFS_IRQS      8'h04
`define LTMF_OFS_IRQCLR    8'h08
`define LTMF_OFS_IRQEN     8'h0C
`define LTMF_OFS_CFG       8'h10

// Control register fields
`define LTMF_CTRL_HVEN     21
`define LTMF_CTRL_SLOPE_LO 11
`define LTMF_CTRL_TXD      9
`define LTMF_CTRL_MODE_LO  1

// Status, clear and enable fields
`define LTMF_IRQ_TXTO_STS  11
`define LTMF_IRQ_OVERTEMP_STATUS    9
`define LTMF_IRQ_ERR_STS   8
`define LTMF_IRQ_TXTO_IS   6
`define LTMF_IRQ_OVERCURRENT_IRQ_FLAG     5
`define LTMF_IRQ_OVERTEMP_IRQ_FLAG     4
`define LTMF_IRQ_ERR_IS    3

// Own configuration register fields
`define LTMF_CFG_TXTO_EN   0
`define LTMF_CFG_OVERCURRENT_STATUS    1
`define LTMF_CFG_STATE_LO  4

// Reset values
`define LTMF_RST_MODE      2'h3
`define LTMF_RST_SLOPE     2'h0
`define LTMF_RST_TXD       1'h1
`define LTMF_RST_HVEN      1'h0
`define LTMF_RST_TXTO_EN   1'h1
`define LTMF_RST_IRQEN     4'h0

// Requested mode codes
`define LTMF_REQ_SLEEP     2'h0
`define LTMF_REQ_LISTEN    2'h1
`define LTMF_REQ_FULL      2'h3

// Feedback codes
`define LTMF_MFB_SLEEP     3'h1
`define LTMF_MFB_LISTEN    3'h5
`define LTMF_MFB_FULL      3'h7
`define LTMF_SFB_MAX       3'h4

// Timing
`define LTMF_CLK_MHZ       50
`define LTMF_TXTO_US       1000
`define LTMF_TXTO_CYC      (`LTMF_TXTO_US * `LTMF_CLK_MHZ)

`endif

// File: verilog/ltmf_core.v
// Function
// - Normal state transmits; slope writes blocked there
// - Receive-only disables transmitter; software or error
// - Sleep: only wake receiver; wake unless disabled
// - Wake on falling edge; sleep allowed while dominant
// - High-voltage state: software transmit and receive bits
// - Sleep to receive-only on request, feedback ok
// - Receive-only to sleep when sleep requested
// - Sleep to normal only without any fault
// - Normal to sleep when sleep requested
// - Normal drops to receive-only on any fault
// - Receive-only to normal only without faults
// - Sleep to high-voltage after entry bit, then normal
// - High-voltage back to sleep on request or fault; here a sleep request needs the entry bit still set, undervoltage is ignored
// - Transmit dominant timeout: receive-only, recessive, flag
// - Transmitter back after dominant ends and flag cleared
// - Timeout supervision optional, enabled after reset
// - Overcurrent: receive-only, status, flag resets while present
// - Overcurrent interrupt gated by enable, shared line
// - Overtemperature: receive-only, recessive, flag, cleared later
// - Overtemperature interrupt gated by enable, shared line
// - Mode feedback decode, other patterns are errors
// - Slope feedback decode, 101 to 111 are errors
// - Mode field: 00 sleep, 01 receive, 11 normal
// - Slope field: normal, fast, low, flash codes
// - High-voltage entry bit acts only in sleep; here it is also needed for the sleep request in high-voltage
// - High-voltage transmit bit 0 pulls line low
//
// Design decisions made here: the APB register port and the address map.
`include "ltmf_defs.vh"

module ltmf_core #(
  parameter [31:0] TXTO_CYCLES = `LTMF_TXTO_CYC
) (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        ce,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  input  wire [2:0]  modeFeedbackBits,
  input  wire        slopeFeedbackBit2,
  input  wire        slopeFeedbackBit1,
  input  wire        slopeFeedbackBit0,
  input  wire        vsUndervolt,
  input  wire        overCurrent,
  input  wire        overTemp,
  input  wire        linRxd,
  input  wire        uartTxd,
  input  wire        busWakeDisable,
  output reg         linDrvOn,
  output reg         txEnable,
  output reg         rxEnable,
  output reg         wakeRxEnable,
  output reg  [1:0]  modeCmd,
  output reg  [1:0]  slopeCmd,
  output reg         uartRxd,
  output reg         busWake,
  output reg         sharedTransceiverIrqNode
);

  localparam [1:0] BUS_SLEEP_STATE   = 2'h0;
  localparam [1:0] LISTEN_ONLY_STATE = 2'h1;
  localparam [1:0] FULL_DUPLEX_STATE = 2'h2;
  localparam [1:0] HV_PIN_IO_STATE   = 2'h3;

  function modeFbOk;
    input [2:0] fb;
    begin
      modeFbOk = (fb == `LTMF_MFB_SLEEP) || (fb == `LTMF_MFB_LISTEN) ||
                 (fb == `LTMF_MFB_FULL);
    end
  endfunction

  function slopeFbOk;
    input [2:0] fb;
    begin
      slopeFbOk = (fb <= `LTMF_SFB_MAX);
    end
  endfunction

  // Three-stage synchroniser, a bit goes high once stages two and three are both high, low once they differ, and holds while both are low
  reg  [9:0] syncA_q;
  reg  [9:0] syncB_q;
  reg  [9:0] syncC_q;
  reg  [9:0] filt_q;
  wire [9:0] anaIn;
  wire [9:0] filt_d;

  assign anaIn  = {linRxd, overTemp, overCurrent, vsUndervolt,
                   slopeFeedbackBit2, slopeFeedbackBit1, slopeFeedbackBit0,
                   modeFeedbackBits};
  assign filt_d = (syncB_q & syncC_q) | (filt_q & ~(syncB_q ^ syncC_q));

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      syncA_q <= 10'h200;
      syncB_q <= 10'h200;
      syncC_q <= 10'h200;
      filt_q  <= 10'h200;
    end else if (ce) begin
      syncA_q <= anaIn;
      syncB_q <= syncA_q;
      syncC_q <= syncB_q;
      filt_q  <= filt_d;
    end
  end

  wire [2:0] modeFb   = filt_q[2:0];
  wire [2:0] slopeFb  = filt_q[5:3];
  wire       uvFlt    = filt_q[6];
  wire       ocFlt    = filt_q[7];
  wire       otFlt    = filt_q[8];
  wire       linFlt   = filt_q[9];
  wire       modeErr  = !modeFbOk(modeFb);
  wire       slopeErr = !slopeFbOk(slopeFb);
  wire       fbOk     = !modeErr && !slopeErr;

  // Registers
  reg [1:0]  state_q;
  reg [1:0]  state_d;
  reg [1:0]  reqMode_q;
  reg [1:0]  slope_q;
  reg        txdBit_q;
  reg        hvEn_q;
  reg        hvArmed_q;
  reg        txtoEn_q;
  reg [3:0]  irqEn_q;
  reg        txtoSts_q;
  reg        otSts_q;
  reg        errSts_q;
  reg        txtoIs_q;
  reg        ocIs_q;
  reg        otIs_q;
  reg        errIs_q;
  reg        ocSts_q;
  reg [31:0] domCnt_q;
  reg        linPrev_q;

  wire accessPh = psel && penable;
  wire wrStb    = accessPh && pwrite && pready;
  wire wrCtrl   = wrStb && (paddr == `LTMF_OFS_CTRL);
  wire wrClr    = wrStb && (paddr == `LTMF_OFS_IRQCLR);
  wire wrEn     = wrStb && (paddr == `LTMF_OFS_IRQEN);
  wire wrCfg    = wrStb && (paddr == `LTMF_OFS_CFG);
  wire mapped   = (paddr == `LTMF_OFS_CTRL) || (paddr == `LTMF_OFS_IRQS) ||
                  (paddr == `LTMF_OFS_IRQCLR) || (paddr == `LTMF_OFS_IRQEN) ||
                  (paddr == `LTMF_OFS_CFG);
  wire [1:0] wrMode = pwdata[`LTMF_CTRL_MODE_LO+1:`LTMF_CTRL_MODE_LO];

  // Dominant supervision
  wire domLong = txtoEn_q && (domCnt_q >= TXTO_CYCLES);

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      domCnt_q <= 32'h0000_0000;
    end else if (ce) begin
      if (uartTxd || !txtoEn_q) begin
        domCnt_q <= 32'h0000_0000;
      end else if (domCnt_q < TXTO_CYCLES) begin
        domCnt_q <= domCnt_q + 32'h0000_0001;
      end
    end
  end

  // Software registers
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      reqMode_q <= `LTMF_RST_MODE;
      slope_q   <= `LTMF_RST_SLOPE;
      txdBit_q  <= `LTMF_RST_TXD;
      hvEn_q    <= `LTMF_RST_HVEN;
      hvArmed_q <= 1'b0;
      txtoEn_q  <= `LTMF_RST_TXTO_EN;
      irqEn_q   <= `LTMF_RST_IRQEN;
    end else if (ce) begin
      if (wrCtrl) begin
        reqMode_q <= wrMode;
        txdBit_q  <= pwdata[`LTMF_CTRL_TXD];
        hvEn_q    <= pwdata[`LTMF_CTRL_HVEN];
        hvArmed_q <= hvEn_q && pwdata[`LTMF_CTRL_HVEN] &&
                     (wrMode == `LTMF_REQ_FULL);
        if (state_q != FULL_DUPLEX_STATE) begin
          slope_q <= pwdata[`LTMF_CTRL_SLOPE_LO+1:`LTMF_CTRL_SLOPE_LO];
        end
      end
      if (wrEn) begin
        irqEn_q <= pwdata[`LTMF_IRQ_TXTO_IS:`LTMF_IRQ_ERR_IS];
      end
      if (wrCfg) begin
        txtoEn_q <= pwdata[`LTMF_CFG_TXTO_EN];
      end
    end
  end

  // Sticky flags; a set in the clearing cycle wins
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      txtoSts_q <= 1'b0;
      otSts_q   <= 1'b0;
      errSts_q  <= 1'b0;
      txtoIs_q  <= 1'b0;
      ocIs_q    <= 1'b0;
      otIs_q    <= 1'b0;
      errIs_q   <= 1'b0;
      ocSts_q   <= 1'b0;
    end else if (ce) begin
      txtoSts_q <= domLong ||
                   (txtoSts_q && !(wrClr && pwdata[`LTMF_IRQ_TXTO_STS]));
      txtoIs_q  <= domLong ||
                   (txtoIs_q && !(wrClr && pwdata[`LTMF_IRQ_TXTO_IS]));
      otSts_q   <= otFlt ||
                   (otSts_q && !(wrClr && pwdata[`LTMF_IRQ_OVERTEMP_STATUS]));
      otIs_q    <= otFlt ||
                   (otIs_q && !(wrClr && pwdata[`LTMF_IRQ_OVERTEMP_IRQ_FLAG]));
      ocIs_q    <= ocFlt ||
                   (ocIs_q && !(wrClr && pwdata[`LTMF_IRQ_OVERCURRENT_IRQ_FLAG]));
      ocSts_q   <= ocFlt ||
                   (ocSts_q && !(wrCfg && pwdata[`LTMF_CFG_OVERCURRENT_STATUS]));
      errSts_q  <= !fbOk ||
                   (errSts_q && !(wrClr && pwdata[`LTMF_IRQ_ERR_STS]));
      errIs_q   <= !fbOk ||
                   (errIs_q && !(wrClr && pwdata[`LTMF_IRQ_ERR_IS]));
    end
  end

  // Mode state machine
  wire faultFree = !uvFlt && !otSts_q && !ocIs_q && !txtoSts_q;

  always @* begin
    state_d = state_q;
    case (state_q)
      BUS_SLEEP_STATE: begin
        if (hvEn_q && hvArmed_q && (reqMode_q == `LTMF_REQ_FULL) && fbOk &&
            !otSts_q && !ocSts_q) begin
          state_d = HV_PIN_IO_STATE;
        end else if ((reqMode_q == `LTMF_REQ_LISTEN) && fbOk && !hvEn_q) begin
          state_d = LISTEN_ONLY_STATE;
        end else if ((reqMode_q == `LTMF_REQ_FULL) && fbOk && !hvEn_q &&
                     faultFree) begin
          state_d = FULL_DUPLEX_STATE;
        end
      end
      LISTEN_ONLY_STATE: begin
        if (reqMode_q == `LTMF_REQ_SLEEP) begin
          state_d = BUS_SLEEP_STATE;
        end else if ((reqMode_q == `LTMF_REQ_FULL) && fbOk && !ocSts_q &&
                     faultFree && !domLong && !otFlt) begin
          state_d = FULL_DUPLEX_STATE;
        end
      end
      FULL_DUPLEX_STATE: begin
        if (reqMode_q == `LTMF_REQ_SLEEP) begin
          state_d = BUS_SLEEP_STATE;
        end else if ((reqMode_q != `LTMF_REQ_FULL) || !fbOk || !faultFree ||
                     domLong || ocFlt || otFlt) begin
          state_d = LISTEN_ONLY_STATE;
        end
      end
      HV_PIN_IO_STATE: begin
        if (((reqMode_q == `LTMF_REQ_SLEEP) && hvEn_q) || !fbOk ||
            otSts_q || ocSts_q) begin
          state_d = BUS_SLEEP_STATE;
        end
      end
      default: begin
        state_d = BUS_SLEEP_STATE;
      end
    endcase
  end

  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_q <= BUS_SLEEP_STATE;
    end else if (ce) begin
      state_q <= state_d;
    end
  end

  // Analog controls and bit paths
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      linDrvOn     <= 1'b0;
      txEnable     <= 1'b0;
      rxEnable     <= 1'b0;
      wakeRxEnable <= 1'b0;
      modeCmd      <= `LTMF_REQ_SLEEP;
      slopeCmd     <= `LTMF_RST_SLOPE;
      uartRxd      <= 1'b1;
      busWake      <= 1'b0;
      linPrev_q    <= 1'b1;
      sharedTransceiverIrqNode <= 1'b0;
    end else if (ce) begin
      txEnable     <= (state_d == FULL_DUPLEX_STATE) ||
                      (state_d == HV_PIN_IO_STATE);
      rxEnable     <= (state_d != BUS_SLEEP_STATE);
      wakeRxEnable <= (state_d == BUS_SLEEP_STATE) && !busWakeDisable;
      slopeCmd     <= slope_q;
      case (state_d)
        FULL_DUPLEX_STATE: begin
          modeCmd  <= `LTMF_REQ_FULL;
          linDrvOn <= !uartTxd && !domLong;
        end
        LISTEN_ONLY_STATE: begin
          modeCmd  <= `LTMF_REQ_LISTEN;
          linDrvOn <= 1'b0;
        end
        HV_PIN_IO_STATE: begin
          modeCmd  <= `LTMF_REQ_FULL;
          linDrvOn <= !txdBit_q;
        end
        default: begin
          modeCmd  <= `LTMF_REQ_SLEEP;
          linDrvOn <= 1'b0;
        end
      endcase
      uartRxd   <= ((state_d == LISTEN_ONLY_STATE) ||
                    (state_d == FULL_DUPLEX_STATE)) ? linFlt : 1'b1;
      linPrev_q <= linFlt;
      busWake   <= (state_d == BUS_SLEEP_STATE) && !busWakeDisable &&
                   linPrev_q && !linFlt;
      sharedTransceiverIrqNode <= |(irqEn_q & {txtoIs_q, ocIs_q, otIs_q, errIs_q});
    end
  end

  // APB slave: one wait state, answer on the second access cycle
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
      prdata  <= 32'h0000_0000;
    end else if (ce) begin
      pready  <= accessPh && !pready;
      pslverr <= accessPh && !pready && !mapped;
      if (accessPh && !pready && !pwrite) begin
        case (paddr)
          `LTMF_OFS_CTRL: begin
            prdata <= {9'h000, 1'b1, hvEn_q, 2'h3, 3'h0, slopeFb, slope_q,
                       linFlt, txdBit_q, 2'h0, modeFb, 1'b0, reqMode_q,
                       1'b1};
          end
          `LTMF_OFS_IRQS: begin
            prdata <= {20'h0_0000, txtoSts_q, 1'b0, otSts_q, errSts_q, 1'b0,
                       txtoIs_q, ocIs_q, otIs_q, errIs_q, 3'h7};
          end
          `LTMF_OFS_IRQCLR: begin
            prdata <= {29'h0000_0000, 3'h7};
          end
          `LTMF_OFS_IRQEN: begin
            prdata <= {25'h000_0000, irqEn_q, 3'h7};
          end
          `LTMF_OFS_CFG: begin
            prdata <= {26'h000_0000, state_q, 2'h0, ocSts_q, txtoEn_q};
          end
          default: begin
            prdata <= 32'h0000_0000;
          end
        endcase
      end else begin
        prdata <= 32'h0000_0000;
      end
    end
  end

endmodule

// File: tb/ltmf_partner.sv
module ltmf_partner (
  input  logic [1:0] modeCmd,
  input  logic [1:0] slopeCmd,
  input  logic       linDrvOn,
  input  logic       busPull,
  input  logic       fbBad,
  output logic [2:0] modeFeedbackBits,
  output logic [2:0] slopeFb,
  output logic       linRxd
);
  timeunit 1ns;
  timeprecision 1ps;
  always_comb begin
    case (modeCmd)
      2'h0: modeFeedbackBits = 3'h1;
      2'h1: modeFeedbackBits = 3'h5;
      default: modeFeedbackBits = 3'h7;
    endcase
    if (fbBad) modeFeedbackBits = 3'h0;
    case (slopeCmd)
      2'h0: slopeFb = 3'h2;
      2'h1: slopeFb = 3'h3;
      2'h2: slopeFb = 3'h1;
      default: slopeFb = 3'h4;
    endcase
  end
  // Pull-up line, low when any node drives
  assign linRxd = !(linDrvOn || busPull);
endmodule

// File: tb/ltmf_core_props.sv
module ltmf_core_props #(
  parameter int TXTO_CYCLES = 20
) (
  input logic        clk,
  input logic        arst_n,
  input logic        psel,
  input logic        penable,
  input logic        pwrite,
  input logic [7:0]  paddr,
  input logic [31:0] pwdata,
  input logic        pready,
  input logic        pslverr,
  input logic        uartTxd,
  input logic        overCurrent,
  input logic        overTemp,
  input logic        linDrvOn,
  input logic        txEnable,
  input logic        rxEnable,
  input logic        wakeRxEnable,
  input logic [1:0]  modeCmd,
  input logic [1:0]  slopeCmd,
  input logic        uartRxd,
  input logic        busWake,
  input logic        sharedTransceiverIrqNode
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0]  irqEn_q;
  logic [15:0] lowCnt_q;
  logic        toEn_q;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      irqEn_q  <= 4'h0;
      lowCnt_q <= 16'h0000;
      toEn_q   <= 1'b1;
    end else begin
      if (psel && penable && pwrite && pready && paddr == 8'h0c) irqEn_q <= pwdata[6:3];
      if (psel && penable && pwrite && pready && paddr == 8'h10) toEn_q <= pwdata[0];
      lowCnt_q <= (uartTxd || !toEn_q) ? 16'h0000 : lowCnt_q + 16'h0001;
    end
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  a_apb_one_wait: assert property ($rose(psel && penable) |=> pready)
    else $error("access not answered after one wait state");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_unmapped: assert property (pready |-> pslverr == (paddr > 8'h10 || paddr[1:0] != 2'h0))
    else $error("error response does not match address");
  a_sleep_paths_off: assert property (modeCmd == 2'h0 |-> !txEnable && !rxEnable && uartRxd)
    else $error("paths active in sleep");
  a_listen_tx_off: assert property (modeCmd == 2'h1 |-> !txEnable && !linDrvOn && rxEnable)
    else $error("transmitter active in receive-only");
  a_wake_sleep_only: assert property (wakeRxEnable || busWake |-> modeCmd == 2'h0)
    else $error("wake path outside sleep");
  a_slope_locked: assert property (modeCmd == 2'h3 && $past(modeCmd) == 2'h3 |-> $stable(slopeCmd))
    else $error("slope changed in normal state");
  a_fault_drop: assert property ((overCurrent || overTemp) [*8] |-> !txEnable)
    else $error("transmitter still on under fault");
  a_irq_gated: assert property (irqEn_q == 4'h0 [*2] |-> !sharedTransceiverIrqNode)
    else $error("interrupt with all enables clear");
  a_timeout_quiet: assert property (lowCnt_q > TXTO_CYCLES + 4 |-> !linDrvOn && !txEnable)
    else $error("line driven after dominant timeout");
  c_listen: cover property (modeCmd == 2'h1);
  c_wake: cover property (busWake);
  c_irq: cover property (sharedTransceiverIrqNode);
endmodule

bind ltmf_core ltmf_core_props #(.TXTO_CYCLES(TXTO_CYCLES)) i_ltmf_core_props (
  .clk, .arst_n, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr, .uartTxd,
  .overCurrent, .overTemp, .linDrvOn, .txEnable, .rxEnable, .wakeRxEnable, .modeCmd,
  .slopeCmd, .uartRxd, .busWake, .sharedTransceiverIrqNode
);

// File: tb/lin_transceiver_mode_fsm_tb_top.sv
`include "ltmf_defs.vh"
module lin_transceiver_mode_fsm_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TXTO = 20;
  logic        clk, arst_n, ce, psel, penable, pwrite, pready, pslverr, err;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, rd, v, seed;
  logic [2:0]  modeFeedbackBits, slopeFb;
  logic        vsUndervolt, overCurrent, overTemp, uartTxd, busWakeDisable, busPull, fbBad;
  logic        linRxd, linDrvOn, txEnable, rxEnable, wakeRxEnable, uartRxd, busWake, irq;
  logic        wakeSeen = 1'b0;
  logic [1:0]  modeCmd, slopeCmd;
  int          errors, compares, i;
  logic [7:0]  ra [4] = '{8'h00, 8'h08, 8'h0c, 8'h10};
  logic [31:0] re [4] = '{32'h0058_4677, 32'h0000_0007, 32'h0000_0007, 32'h0000_0021};

  ltmf_core #(.TXTO_CYCLES(TXTO)) i_ltmf_core (
    .clk, .arst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
    .pslverr, .modeFeedbackBits, .slopeFeedbackBit2(slopeFb[2]), .slopeFeedbackBit1(slopeFb[1]),
    .slopeFeedbackBit0(slopeFb[0]), .vsUndervolt, .overCurrent, .overTemp, .linRxd, .uartTxd,
    .busWakeDisable, .linDrvOn, .txEnable, .rxEnable, .wakeRxEnable, .modeCmd, .slopeCmd,
    .uartRxd, .busWake, .sharedTransceiverIrqNode(irq)
  );
  ltmf_partner i_ltmf_partner (
    .modeCmd, .slopeCmd, .linDrvOn, .busPull, .fbBad, .modeFeedbackBits, .slopeFb, .linRxd
  );

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk) if (busWake === 1'b1) wakeSeen <= 1'b1;

  function automatic logic [31:0] ctrl(input logic h, input logic [1:0] s, input logic t,
                                       input logic [1:0] m);
    return {10'h000, h, 8'h00, s, 1'b0, t, 6'h00, m, 1'b0};
  endfunction
  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1 && n < 20) begin
      @(posedge clk);
      n++;
    end
    if (n == 20) errors++;
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic summarize();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    #(20 * 20000);
    errors++;
    summarize();
  end

  initial begin
    seed = 32'h375e_17ba;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {vsUndervolt, overCurrent, overTemp, busWakeDisable, busPull, fbBad} = '0;
    uartTxd = 1'b1;
    ce = 1'b1;
    arst_n = 1'b0;
    wt(2);
    arst_n <= 1'b1;
    wt(15);
    chk(modeCmd, 2'h3);
    for (i = 0; i < 4; i++) begin
      apb(1'b0, ra[i], 32'h0);
      chk(rd, re[i]);
    end
    apb(1'b0, 8'h14, 32'h0);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    for (i = 0; i < 4; i++) begin
      v = $random(seed);
      apb(1'b1, `LTMF_OFS_IRQEN, v);
      apb(1'b0, `LTMF_OFS_IRQEN, 32'h0);
      chk(rd, (v & 32'h0000_0078) | 32'h0000_0007);
    end
    apb(1'b1, `LTMF_OFS_IRQCLR, 32'h0000_0ff8);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'h1, 1'b1, 2'h3));
    wt(2);
    chk(slopeCmd, 2'h0);
    for (i = 3; i >= 0; i--) begin
      apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'(i), 1'b1, 2'h1));
      apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'(i), 1'b1, 2'h1));
      wt(12);
      chk({modeCmd, slopeCmd}, {2'h1, 2'(i)});
      apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'(i), 1'b1, 2'h3));
      wt(12);
      chk(modeCmd, 2'h3);
    end
    for (i = 0; i < 5; i++) begin
      @(posedge clk);
      {fbBad, vsUndervolt, overTemp, overCurrent} <= 4'(5'b1 << i);
      uartTxd <= (i != 4);
      wt(TXTO + 10);
      chk({modeCmd, linDrvOn}, 3'h2);
      apb(1'b1, `LTMF_OFS_IRQEN, 32'h0000_0078);
      wt(3);
      chk(irq, i != 2);
      apb(1'b1, `LTMF_OFS_IRQCLR, 32'h0000_0ff8);
      wt(3);
      if (i < 4) chk(irq, i != 2);
      @(posedge clk);
      {fbBad, vsUndervolt, overTemp, overCurrent} <= 4'h0;
      uartTxd <= 1'b1;
      wt(10);
      apb(1'b1, `LTMF_OFS_IRQCLR, 32'h0000_0ff8);
      apb(1'b1, `LTMF_OFS_CFG, 32'h0000_0003);
      apb(1'b1, `LTMF_OFS_IRQEN, 32'h0);
      wt(3);
      chk(irq, 1'b0);
      apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'h0, 1'b1, 2'h3));
      wt(12);
      chk(modeCmd, 2'h3);
    end
    apb(1'b1, `LTMF_OFS_CFG, 32'h0000_0000);
    uartTxd <= 1'b0;
    wt(TXTO + 10);
    chk({modeCmd, linDrvOn}, 3'h7);
    uartTxd <= 1'b1;
    apb(1'b1, `LTMF_OFS_CFG, 32'h0000_0001);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'h0, 1'b1, 2'h0));
    wt(10);
    chk({modeCmd, wakeRxEnable}, 3'h1);
    for (i = 0; i < 6; i++) begin
      v = $random(seed);
      busWakeDisable <= v[0];
      wt(3);
      chk(wakeRxEnable, !v[0]);
    end
    busWakeDisable <= 1'b0;
    wt(3);
    ce <= 1'b0;
    busWakeDisable <= 1'b1;
    wt(4);
    chk(wakeRxEnable, 1'b1);
    ce <= 1'b1;
    busWakeDisable <= 1'b0;
    busPull <= 1'b1;
    wt(10);
    chk(wakeSeen, 1'b1);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'h0, 1'b1, 2'h1));
    wt(12);
    chk(modeCmd, 2'h1);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b0, 2'h0, 1'b1, 2'h0));
    wt(12);
    chk(modeCmd, 2'h0);
    busPull <= 1'b0;
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b1, 2'h0, 1'b1, 2'h0));
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b1, 2'h0, 1'b0, 2'h3));
    wt(10);
    chk({modeCmd, linDrvOn}, 3'h7);
    apb(1'b0, `LTMF_OFS_CFG, 32'h0);
    chk({rd[5:4], rd[1]}, 3'h6);
    apb(1'b0, `LTMF_OFS_CTRL, 32'h0);
    chk(rd[10], 1'b0);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b1, 2'h0, 1'b1, 2'h3));
    wt(8);
    apb(1'b0, `LTMF_OFS_CTRL, 32'h0);
    chk({linDrvOn, rd[10]}, 2'h1);
    apb(1'b1, `LTMF_OFS_CTRL, ctrl(1'b1, 2'h0, 1'b1, 2'h0));
    wt(10);
    chk(modeCmd, 2'h0);
    summarize();
  end
endmodule
